//--- core/ep0_pkg.sv
// Constants and carrier types for the endpoint 0 control/status block
package ep0_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // Printed offsets are register indices; byte address is index times four
  localparam logic [9:0] CSR_LOW_IDX = 10'h102;
  localparam logic [9:0] TOGGLE_IDX = 10'h140;
  localparam logic [7:0] CSR_LOW_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Host role bit positions
  localparam int H_NAK_TIMEOUT = 7;
  localparam int H_STATUS = 6;
  localparam int H_IN_REQUEST = 5;
  localparam int H_ERROR = 4;
  localparam int H_SETUP = 3;
  // Device role bit positions
  localparam int D_SETUP_END_CLEAR = 7;
  localparam int D_RX_READY_CLEAR = 6;
  localparam int D_SEND_STALL = 5;
  localparam int D_SETUP_END = 4;
  localparam int D_LAST_DATA = 3;
  // Shared bit positions
  localparam int B_STALLED = 2;
  localparam int B_TX_READY = 1;
  localparam int B_RX_READY = 0;
  // Toggle status register bit positions
  localparam int T_TOGGLE = 0;
  localparam int T_ROLE = 1;
  localparam logic [1:0] NO_RESP_LIMIT = 2'h3;

  // One-cycle event pulses from the packet engine
  typedef struct packed {
    logic nak_limit_hit;
    logic no_response;
    logic stall_rx;
    logic stall_sent;
    logic tx_done;
    logic rx_done;
    logic ctrl_end;
    logic toggle_flip;
  } link_evt_s;

  // Requests toward the packet engine
  typedef struct packed {
    logic tx_ready;
    logic setup_token;
    logic in_request;
    logic status_stage;
    logic stall_req;
    logic halted;
    logic fifo_flush;
    logic toggle;
  } link_cmd_s;
endpackage

//--- core/sticky_flag.sv
// Single status flag with set taking priority over clear
`timescale 1ns/1ns
module sticky_flag (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic set,
  input wire logic clr,
  output logic q
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end
endmodule // sticky_flag

//--- core/axil_slave.sv
// AXI4-Lite slave front end producing single-cycle register strobes
`timescale 1ns/1ns
module axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ep0_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ep0_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ep0_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [ep0_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_req,
  output logic [ep0_pkg::ADDR_W-1:0] wr_addr,
  output logic [ep0_pkg::DATA_W-1:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic [ep0_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [ep0_pkg::DATA_W-1:0] rd_data,
  input wire logic rd_err
);
  import ep0_pkg::*;

  logic aw_have_ff;
  logic w_have_ff;
  logic nxt_aw_have;
  logic nxt_w_have;
  logic nxt_bvalid;
  logic nxt_rvalid;

  assign wr_req = aw_have_ff && w_have_ff && !bvalid;
  assign rd_addr = araddr;

  always_comb begin
    nxt_aw_have = aw_have_ff;
    nxt_w_have = w_have_ff;
    nxt_bvalid = bvalid;
    if (awvalid && awready) begin
      nxt_aw_have = 1'b1;
    end
    if (wvalid && wready) begin
      nxt_w_have = 1'b1;
    end
    if (bvalid && bready) begin
      nxt_bvalid = 1'b0;
    end
    if (wr_req) begin
      nxt_aw_have = 1'b0;
      nxt_w_have = 1'b0;
      nxt_bvalid = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= 4'h0;
    end else begin
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      bvalid <= nxt_bvalid;
      awready <= !nxt_aw_have && !nxt_bvalid;
      wready <= !nxt_w_have && !nxt_bvalid;
      if (awvalid && awready) begin
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_req) begin
        bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  always_comb begin
    nxt_rvalid = rvalid;
    if (rvalid && rready) begin
      nxt_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      nxt_rvalid = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        rdata <= rd_err ? '0 : rd_data;
        rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end
      rvalid <= nxt_rvalid;
      arready <= !nxt_rvalid && !(arvalid && arready);
    end
  end
endmodule // axil_slave

//--- core/ep0_csr_low.sv
// Endpoint 0 low control/status register with host and device role behaviour
`timescale 1ns/1ns
// What this block does
// - Host: NAK limit hit sets timeout flag
// - Host: status bit forces data toggle one
// - Host: request bit launches IN, clears on receive
// - Host: three silent attempts set error, interrupt
// - Host: setup with transmit-ready sends SETUP, DATA0
// - Host: received STALL sets stalled until cleared
// - Host: transmit-ready clears after send, interrupts
// - Host: receive sets ready flag; CPU writes zero
// - Device: writing one clears setup-end flag
// - Device: writing one clears receive-ready flag
// - Device: send-stall bit stalls, then self-clears
// - Device: early control end: flag, interrupt, flush
// - Device: last-data bit set by CPU, auto-cleared
// - Device: sent STALL sets stalled; zero clears
// - Device: transmit-ready clears after send, interrupts
// - Device: receive sets read-only ready, interrupts
// - Register is eight bits, resets to zero
// - Data toggle state readable in own register
module ep0_csr_low (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ep0_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ep0_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ep0_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [ep0_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic host_role,
  input wire ep0_pkg::link_evt_s evt,
  output ep0_pkg::link_cmd_s cmd_ff,
  output logic ep0_irq_ff
);
  import ep0_pkg::*;

  logic wr_req;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0] wr_strb;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic wr_err;
  logic rd_err;
  logic we;
  logic [7:0] d;
  logic [7:0] csr_rd;
  logic host_we;
  logic dev_we;

  logic nak_timeout_flag;
  logic error_flag;
  logic stalled_flag;
  logic tx_packet_ready;
  logic rx_packet_ready;
  logic setup_end_flag;
  logic stall_req_flag;
  logic last_data_flag;
  logic setup_flag;
  logic status_ff;
  logic in_request_bit_ff;
  logic toggle_state_bit_ff;
  logic [1:0] no_resp_cnt_ff;
  logic err_hit;
  logic early_end;

  axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_req(wr_req),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // Address decode; the control register sits in byte lane 0
  assign wr_err = (wr_addr[ADDR_W-1:2] != CSR_LOW_IDX) && (wr_addr[ADDR_W-1:2] != TOGGLE_IDX);
  assign rd_err = (rd_addr[ADDR_W-1:2] != CSR_LOW_IDX) && (rd_addr[ADDR_W-1:2] != TOGGLE_IDX);
  assign we = wr_req && wr_strb[0] && (wr_addr[ADDR_W-1:2] == CSR_LOW_IDX);
  assign d = wr_data[7:0];
  assign host_we = we && host_role;
  assign dev_we = we && !host_role;

  // Third consecutive silent attempt
  assign err_hit = host_role && evt.no_response && (no_resp_cnt_ff == NO_RESP_LIMIT - 2'h1);
  assign early_end = !host_role && evt.ctrl_end && !last_data_flag;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      no_resp_cnt_ff <= 2'h0;
    end else if (evt.tx_done || evt.rx_done || evt.stall_rx || err_hit) begin
      no_resp_cnt_ff <= 2'h0;
    end else if (host_role && evt.no_response) begin
      no_resp_cnt_ff <= no_resp_cnt_ff + 2'h1;
    end
  end

  sticky_flag u_nak (
    .aclk(aclk), .aresetn(aresetn),
    .set(host_role && evt.nak_limit_hit),
    .clr(host_we && !d[H_NAK_TIMEOUT]),
    .q(nak_timeout_flag)
  );

  sticky_flag u_err (
    .aclk(aclk), .aresetn(aresetn),
    .set(err_hit),
    .clr(host_we && !d[H_ERROR]),
    .q(error_flag)
  );

  // Host: STALL received; device: STALL sent; written zero clears
  sticky_flag u_stalled (
    .aclk(aclk), .aresetn(aresetn),
    .set(host_role ? evt.stall_rx : evt.stall_sent),
    .clr(we && !d[B_STALLED]),
    .q(stalled_flag)
  );

  sticky_flag u_tx_packet_ready (
    .aclk(aclk), .aresetn(aresetn),
    .set(we && d[B_TX_READY]),
    .clr(evt.tx_done || early_end),
    .q(tx_packet_ready)
  );

  sticky_flag u_rx_packet_ready (
    .aclk(aclk), .aresetn(aresetn),
    .set(evt.rx_done),
    .clr((host_we && !d[B_RX_READY]) || (dev_we && d[D_RX_READY_CLEAR]) || early_end),
    .q(rx_packet_ready)
  );

  sticky_flag u_setup_end_flag (
    .aclk(aclk), .aresetn(aresetn),
    .set(early_end),
    .clr(dev_we && d[D_SETUP_END_CLEAR]),
    .q(setup_end_flag)
  );

  sticky_flag u_stall (
    .aclk(aclk), .aresetn(aresetn),
    .set(dev_we && d[D_SEND_STALL]),
    .clr(evt.stall_sent),
    .q(stall_req_flag)
  );

  sticky_flag u_last (
    .aclk(aclk), .aresetn(aresetn),
    .set(dev_we && d[D_LAST_DATA]),
    .clr(evt.ctrl_end),
    .q(last_data_flag)
  );

  sticky_flag u_setup (
    .aclk(aclk), .aresetn(aresetn),
    .set(host_we && d[H_SETUP]),
    .clr(evt.tx_done),
    .q(setup_flag)
  );

  // Status and request bits are written in host role; status clears after send or receive, request on receive, STALL, error or NAK limit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= CSR_LOW_RESET[H_STATUS];
    end else if (host_we) begin
      status_ff <= d[H_STATUS];
    end else if (evt.tx_done || evt.rx_done) begin
      status_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_request_bit_ff <= CSR_LOW_RESET[H_IN_REQUEST];
    end else if (evt.rx_done || evt.stall_rx || err_hit || evt.nak_limit_hit) begin
      in_request_bit_ff <= 1'b0;
    end else if (host_we) begin
      in_request_bit_ff <= d[H_IN_REQUEST];
    end
  end

  // Data toggle: setup forces DATA0, status forces DATA1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      toggle_state_bit_ff <= 1'b0;
    end else if (host_we && d[H_SETUP] && d[B_TX_READY]) begin
      toggle_state_bit_ff <= 1'b0;
    end else if (host_we && d[H_STATUS]) begin
      toggle_state_bit_ff <= 1'b1;
    end else if (evt.toggle_flip) begin
      toggle_state_bit_ff <= !toggle_state_bit_ff;
    end
  end

  // Read view depends on role
  always_comb begin
    csr_rd = CSR_LOW_RESET;
    csr_rd[B_STALLED] = stalled_flag;
    csr_rd[B_TX_READY] = tx_packet_ready;
    csr_rd[B_RX_READY] = rx_packet_ready;
    if (host_role) begin
      csr_rd[H_NAK_TIMEOUT] = nak_timeout_flag;
      csr_rd[H_STATUS] = status_ff;
      csr_rd[H_IN_REQUEST] = in_request_bit_ff;
      csr_rd[H_ERROR] = error_flag;
      csr_rd[H_SETUP] = setup_flag;
    end else begin
      csr_rd[D_SEND_STALL] = stall_req_flag;
      csr_rd[D_SETUP_END] = setup_end_flag;
      csr_rd[D_LAST_DATA] = last_data_flag;
    end
  end

  always_comb begin
    rd_data = '0;
    if (rd_addr[ADDR_W-1:2] == CSR_LOW_IDX) begin
      rd_data[7:0] = csr_rd;
    end else begin
      rd_data[T_TOGGLE] = toggle_state_bit_ff;
      rd_data[T_ROLE] = host_role;
    end
  end

  // Requests to the packet engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_ff <= '0;
    end else begin
      cmd_ff.tx_ready <= tx_packet_ready;
      cmd_ff.setup_token <= host_role && setup_flag && tx_packet_ready;
      cmd_ff.in_request <= host_role && in_request_bit_ff;
      cmd_ff.status_stage <= host_role && status_ff;
      cmd_ff.stall_req <= !host_role && stall_req_flag;
      cmd_ff.halted <= host_role && nak_timeout_flag;
      cmd_ff.fifo_flush <= early_end;
      cmd_ff.toggle <= toggle_state_bit_ff;
    end
  end

  // One pulse per cycle in which any interrupt cause fires
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ep0_irq_ff <= 1'b0;
    end else begin
      ep0_irq_ff <= evt.tx_done || evt.rx_done || err_hit || early_end;
    end
  end

  a_nak_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
    host_role && evt.nak_limit_hit |=> nak_timeout_flag ##1 cmd_ff.halted)
    else $error("NAK timeout flag not set");

  a_status_toggle_one: assert property (@(posedge aclk) disable iff (!aresetn)
    host_we && d[H_STATUS] && !d[H_SETUP] |=> toggle_state_bit_ff)
    else $error("Status stage did not force toggle one");

  a_req_cleared_rx: assert property (@(posedge aclk) disable iff (!aresetn)
    host_role && evt.rx_done |=> !in_request_bit_ff && rx_packet_ready)
    else $error("IN request not cleared on receive");

  a_error_three_tries: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(error_flag) |-> $past(evt.no_response) && $past(no_resp_cnt_ff) == 2'h2 && ep0_irq_ff)
    else $error("Error flag without three silent attempts");

  a_setup_toggle_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    host_we && d[H_SETUP] && d[B_TX_READY] |=> !toggle_state_bit_ff ##1 cmd_ff.setup_token)
    else $error("Setup did not reset toggle");

  a_tx_done_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    evt.tx_done && !(we && d[B_TX_READY]) |=> !tx_packet_ready && ep0_irq_ff)
    else $error("Transmit ready not cleared with interrupt");

  a_rx_clear_dev: assert property (@(posedge aclk) disable iff (!aresetn)
    dev_we && d[D_RX_READY_CLEAR] && !evt.rx_done |=> !rx_packet_ready)
    else $error("Receive ready clear ignored");

  a_stall_sent_flags: assert property (@(posedge aclk) disable iff (!aresetn)
    !host_role && evt.stall_sent && !(we && d[D_SEND_STALL]) |=> stalled_flag && !stall_req_flag)
    else $error("Stall send not completed");

  a_setup_end_flush: assert property (@(posedge aclk) disable iff (!aresetn)
    early_end |=> setup_end_flag && cmd_ff.fifo_flush && ep0_irq_ff)
    else $error("Early control end not handled");

  a_stalled_w1_noop: assert property (@(posedge aclk) disable iff (!aresetn)
    !stalled_flag && !evt.stall_sent && !evt.stall_rx |=> !stalled_flag)
    else $error("Stalled flag set without a stall");
endmodule // ep0_csr_low

//--- tb/usb_peer_model.sv
// Behavioural bus partner answering endpoint 0 requests with link events
`timescale 1ns/1ns
module usb_peer_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire ep0_pkg::link_cmd_s cmd,
  input wire ep0_pkg::link_evt_s inject,
  input wire logic auto_en,
  input wire logic [3:0] lag,
  output ep0_pkg::link_evt_s evt
);
  import ep0_pkg::*;
  logic [3:0] cnt_ff;
  logic done_ff;
  link_evt_s auto_ff;
  logic busy;
  assign busy = auto_en && (cmd.tx_ready || cmd.in_request || cmd.stall_req);
  assign evt = auto_ff | inject;
  always_ff @(posedge aclk) begin
    auto_ff <= '0;
    if (!aresetn || !busy) begin
      cnt_ff <= 4'h0;
      done_ff <= 1'b0;
    end else if (!done_ff && cnt_ff == lag) begin
      done_ff <= 1'b1;
      // One answer per request, after lag cycles
      auto_ff.tx_done <= cmd.tx_ready;
      auto_ff.rx_done <= cmd.in_request;
      auto_ff.stall_sent <= cmd.stall_req;
      auto_ff.toggle_flip <= cmd.tx_ready || cmd.in_request;
    end else if (!done_ff) begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
endmodule // usb_peer_model

//--- tb/test_ep0_csr_low.sv
// Self-checking bench for the endpoint 0 low control/status block
`timescale 1ns/1ns
module test_ep0_csr_low;
  import ep0_pkg::*;
  localparam logic [11:0] CSR_A = {CSR_LOW_IDX, 2'b00};
  localparam logic [11:0] TGL_A = {TOGGLE_IDX, 2'b00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, ep0_irq_ff;
  logic [1:0] bresp, rresp, last_bresp, last_rresp;
  logic [31:0] rdata, last_rdata;
  logic host_role = 1'b0;
  logic auto_en = 1'b0;
  link_evt_s evt;
  link_evt_s inject = '0;
  link_cmd_s cmd_ff;
  int miscompares = 0;
  int n_checks = 0;
  int irq_cnt = 0;
  int flush_cnt = 0;
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    if (ep0_irq_ff === 1'b1) irq_cnt++;
    if (cmd_ff.fifo_flush === 1'b1) flush_cnt++;
  end
  ep0_csr_low uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .host_role(host_role), .evt(evt), .cmd_ff(cmd_ff),
    .ep0_irq_ff(ep0_irq_ff));
  usb_peer_model peer (.aclk(aclk), .aresetn(aresetn), .cmd(cmd_ff), .inject(inject), .auto_en(auto_en),
    .lag(4'h3), .evt(evt));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic timed_out();
    miscompares++;
    $display("Error at %0t ns: wait timed out", $time);
    tally_and_finish();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bit done;
    done = 0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        last_bresp = bresp;
        done = 1;
      end
    end
    if (!done) timed_out();
  endtask
  task automatic rd(input logic [11:0] a);
    bit done;
    done = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        last_rdata = rdata;
        last_rresp = rresp;
        done = 1;
      end
    end
    if (!done) timed_out();
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    rd(a);
    check(last_rdata, exp);
  endtask
  // Read until the masked bits drop
  task automatic poll_clear(input logic [31:0] mask);
    bit done;
    done = 0;
    for (int n = 0; n < 40 && !done; n++) begin
      rd(CSR_A);
      if ((last_rdata & mask) === 32'h0) done = 1;
    end
    if (!done) timed_out();
  endtask
  task automatic pulse(input int b);
    inject <= link_evt_s'(8'h01 << b);
    @(posedge aclk);
    inject <= '0;
    @(posedge aclk);
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(CSR_A, 32'h0);
    rd_chk(TGL_A, 32'h0);
    wr(12'h004, 32'hff);
    check(32'(last_bresp), 32'(RESP_SLVERR));
    rd_chk(12'h004, 32'h0);
    check(32'(last_rresp), 32'(RESP_SLVERR));
    // Host role: status stage, IN request, setup
    host_role <= 1'b1;
    wr(CSR_A, 32'h42);
    rd_chk(TGL_A, 32'h3);
    rd_chk(CSR_A, 32'h42);
    check(32'({cmd_ff.tx_ready, cmd_ff.status_stage, cmd_ff.toggle}), 32'h7);
    auto_en <= 1'b1;
    poll_clear(32'h02);
    rd_chk(CSR_A, 32'h0);
    check(32'(irq_cnt), 32'h1);
    rd_chk(TGL_A, 32'h2);
    auto_en <= 1'b0;
    wr(CSR_A, 32'h20);
    rd_chk(CSR_A, 32'h20);
    check(32'(cmd_ff.in_request), 32'h1);
    auto_en <= 1'b1;
    poll_clear(32'h20);
    rd_chk(CSR_A, 32'h01);
    check(32'(irq_cnt), 32'h2);
    wr(CSR_A, 32'h00);
    rd_chk(CSR_A, 32'h00);
    auto_en <= 1'b0;
    wr(CSR_A, 32'h0a);
    rd_chk(TGL_A, 32'h2);
    rd_chk(CSR_A, 32'h0a);
    check(32'(cmd_ff.setup_token), 32'h1);
    check(32'(cmd_ff.toggle), 32'h0);
    auto_en <= 1'b1;
    poll_clear(32'h02);
    rd_chk(CSR_A, 32'h0);
    check(32'(irq_cnt), 32'h3);
    pulse(6);
    pulse(6);
    rd_chk(CSR_A, 32'h0);
    pulse(6);
    rd_chk(CSR_A, 32'h10);
    check(32'(irq_cnt), 32'h4);
    wr(CSR_A, 32'h0);
    rd_chk(CSR_A, 32'h0);
    pulse(7);
    rd_chk(CSR_A, 32'h80);
    check(32'(cmd_ff.halted), 32'h1);
    wr(CSR_A, 32'h0);
    rd_chk(CSR_A, 32'h0);
    pulse(5);
    rd_chk(CSR_A, 32'h04);
    wr(CSR_A, 32'h04);
    rd_chk(CSR_A, 32'h04);
    wr(CSR_A, 32'h0);
    rd_chk(CSR_A, 32'h0);
    // Device role
    host_role <= 1'b0;
    rd_chk(TGL_A, 32'h1);
    pulse(2);
    rd_chk(CSR_A, 32'h01);
    check(32'(irq_cnt), 32'h5);
    wr(CSR_A, 32'h01);
    rd_chk(CSR_A, 32'h01);
    wr(CSR_A, 32'h40);
    rd_chk(CSR_A, 32'h0);
    wr(CSR_A, 32'h20);
    poll_clear(32'h20);
    rd_chk(CSR_A, 32'h04);
    wr(CSR_A, 32'h04);
    rd_chk(CSR_A, 32'h04);
    wr(CSR_A, 32'h0);
    rd_chk(CSR_A, 32'h0);
    auto_en <= 1'b0;
    wr(CSR_A, 32'h02);
    pulse(1);
    rd_chk(CSR_A, 32'h10);
    check(32'(flush_cnt), 32'h1);
    check(32'(irq_cnt), 32'h6);
    wr(CSR_A, 32'h80);
    rd_chk(CSR_A, 32'h0);
    wr(CSR_A, 32'h0a);
    rd_chk(CSR_A, 32'h0a);
    pulse(1);
    rd_chk(CSR_A, 32'h02);
    check(32'(flush_cnt), 32'h1);
    auto_en <= 1'b1;
    poll_clear(32'h02);
    rd_chk(CSR_A, 32'h0);
    check(32'(irq_cnt), 32'h7);
    tally_and_finish();
  end
endmodule // test_ep0_csr_low
